// ### rtl/fcls_defs.svh
`ifndef FCLS_DEFS_SVH
`define FCLS_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define FCLS_AW 8
`define FCLS_OFF_THRESH 8'h00
`define FCLS_OFF_CONFIG 8'h04
`define FCLS_OFF_LINKCTL 8'h08
`define FCLS_OFF_MSGCNT 8'h0C
`define FCLS_OFF_PATTERN 8'h10

// ----------------------------------------
// readout configuration fields
// ----------------------------------------
`define FCLS_CFG_PRE 3:0
`define FCLS_CFG_TOTAL 8:4
`define FCLS_CFG_TEST_EN 9
`define FCLS_CFG_TEST_MODE 10
`define FCLS_CFG_BUF_TEST 11
`define FCLS_CFG_GEN_LIMIT 12
`define FCLS_CFG_EMIT_LAST 13
`define FCLS_CFG_EMIT_EMPTY 14
`define FCLS_CFG_DIVISOR 23:16
`define FCLS_CFG_STATUS 30:24
`define FCLS_CFG_RW_MASK 32'h00FF7FFF
`define FCLS_CFG_RESET 32'h00010000

// ----------------------------------------
// link statistics control fields
// ----------------------------------------
`define FCLS_LNK_CHAN 1:0
`define FCLS_LNK_DIR 2
`define FCLS_LNK_KIND 3
`define FCLS_LNK_CAPTURE 4
`define FCLS_LNK_CLEAR 5
`define FCLS_LNK_RW_MASK 32'h0000003F
`define FCLS_THR_RW_MASK 32'hFFFFFFFF

// ----------------------------------------
// constants
// ----------------------------------------
`define FCLS_NUM_VC 3
`define FCLS_NUM_CHIP 4
`define FCLS_TEST_AW 4
`define FCLS_CHAN_ALL 2'h3
`define FCLS_FRAME_PATTERN 12'hFC0
`define FCLS_FRAME_LAST 4'hB
`define FCLS_RESP_OKAY 2'h0
`define FCLS_RESP_SLVERR 2'h2
`define FCLS_ERR_MAX 8'hFF

`endif

// ### rtl/fcls_pkg.sv
`include "fcls_defs.svh"

package fcls_pkg;
	typedef enum logic [1:0] {FCLS_WR_COLLECT = 2'b01, FCLS_WR_RESP = 2'b10} fcls_wr_state_t;
	typedef enum logic [1:0] {FCLS_RD_IDLE = 2'b01, FCLS_RD_DATA = 2'b10} fcls_rd_state_t;

	typedef struct packed {
		fcls_wr_state_t wst;
		fcls_rd_state_t rst;
		logic aw_got;
		logic w_got;
		logic awready;
		logic wready;
		logic arready;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] thr;
		logic [31:0] cfg;
		logic [31:0] lnk;
		logic cap_prev;
		logic [3:0] load_ptr;
		logic [3:0] rd_ptr;
		logic [7:0] div_cnt;
		logic tick;
		logic fs1;
		logic fs2;
		logic [11:0] window;
		logic [3:0] phase;
		logic locked;
		logic [6:0] status;
		logic [31:0] ev_cnt;
		logic gen_run;
		logic trig_accept;
		logic [3:0] local_trig;
		logic [11:0] zs_sample;
		logic [11:0] buf_data;
		logic permit;
	} fcls_state_t;

	typedef struct packed {
		logic [`FCLS_NUM_VC-1:0][31:0] tx;
		logic [`FCLS_NUM_VC-1:0][31:0] rx;
		logic [`FCLS_NUM_VC-1:0][7:0] perr;
		logic [`FCLS_NUM_VC-1:0][7:0] ferr;
		logic [31:0] cap_msg;
		logic [7:0] cap_perr;
		logic [7:0] cap_ferr;
	} fcls_cnt_state_t;
endpackage

// ### rtl/fcls_cnt_if.sv
`timescale 1ns/1ns
`include "fcls_defs.svh"

interface fcls_cnt_if;
	logic capture;
	logic clear;
	logic [1:0] chan;
	logic dir;
	logic [`FCLS_NUM_VC-1:0] ev_tx;
	logic [`FCLS_NUM_VC-1:0] ev_rx;
	logic [`FCLS_NUM_VC-1:0] ev_par;
	logic [`FCLS_NUM_VC-1:0] ev_fmt;
	logic [31:0] cap_msg;
	logic [7:0] cap_perr;
	logic [7:0] cap_ferr;
	modport ctrl(output capture, clear, chan, dir, ev_tx, ev_rx, ev_par, ev_fmt,
		input cap_msg, cap_perr, cap_ferr);
	modport bank(input capture, clear, chan, dir, ev_tx, ev_rx, ev_par, ev_fmt,
		output cap_msg, cap_perr, cap_ferr);
endinterface

// ### rtl/fcls_link_counters.sv
`timescale 1ns/1ns
`include "fcls_defs.svh"

module fcls_link_counters (
	input wire logic i_clock,
	input wire logic i_clk_en,
	input wire logic i_rst,
	fcls_cnt_if.bank bank
);
	fcls_pkg::fcls_cnt_state_t q, d;

	function automatic logic [7:0] fcls_sat_inc(input logic [7:0] v, input logic ev);
		return (ev && v != `FCLS_ERR_MAX) ? v + 8'h01 : v;
	endfunction

	// ----------------------------------------
	// counting, clearing, capture
	// ----------------------------------------
	always_comb begin
		d = q;
		for (int c = 0; c < `FCLS_NUM_VC; c++) begin
			if (bank.clear && (bank.chan == `FCLS_CHAN_ALL || bank.chan == 2'(c))) begin
				d.tx[c] = 32'h0;
				d.rx[c] = 32'h0;
				d.perr[c] = 8'h00;
				d.ferr[c] = 8'h00;
			end else begin
				d.tx[c] = q.tx[c] + 32'(bank.ev_tx[c]);
				d.rx[c] = q.rx[c] + 32'(bank.ev_rx[c]);
				d.perr[c] = fcls_sat_inc(q.perr[c], bank.ev_par[c]);
				d.ferr[c] = fcls_sat_inc(q.ferr[c], bank.ev_fmt[c]);
			end
		end
		if (bank.capture && bank.chan != `FCLS_CHAN_ALL) begin
			if (bank.dir) begin
				d.cap_msg = q.tx[bank.chan];
			end else begin
				d.cap_msg = q.rx[bank.chan];
				d.cap_perr = q.perr[bank.chan];
				d.cap_ferr = q.ferr[bank.chan];
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else if (i_clk_en) begin
			q <= d;
		end
	end

	assign bank.cap_msg = q.cap_msg;
	assign bank.cap_perr = q.cap_perr;
	assign bank.cap_ferr = q.cap_ferr;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	a_err_saturate: assert property (
		i_clk_en && q.perr[2] == `FCLS_ERR_MAX && !bank.clear |=> q.perr[2] == `FCLS_ERR_MAX)
		else $error("parity error count left saturation");
	a_clear_all: assert property (
		i_clk_en && bank.clear && bank.chan == `FCLS_CHAN_ALL
		|=> q.tx == '0 && q.rx == '0 && q.perr == '0 && q.ferr == '0)
		else $error("clear with all-channel code left a counter set");
	a_tx_capture: assert property (
		i_clk_en && bank.capture && bank.dir && bank.chan == 2'h0
		|=> q.cap_msg == $past(q.tx[0]) && $stable(q.cap_perr))
		else $error("transmit capture took wrong values");
endmodule

// ### rtl/fcls_top.sv
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "fcls_defs.svh"


module fcls_top (
	input wire logic i_clock,
	input wire logic i_clk_en,
	input wire logic i_rst,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [`FCLS_AW-1:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [`FCLS_AW-1:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic [31:0] i_multiplicity,
	output logic [3:0] o_local_trigger,
	input wire logic i_sample_valid,
	input wire logic [11:0] i_adc_sample,
	input wire logic [11:0] i_sample_address,
	output logic [11:0] o_zs_sample,
	output logic [3:0] o_presamples_count,
	output logic [4:0] o_pre_post_sample_total,
	input wire logic [11:0] i_event_buffer_pointer,
	output logic [11:0] o_buffer_data,
	input wire logic i_acq_enable,
	input wire logic i_gen_event,
	input wire logic i_event_captured,
	input wire logic [31:0] i_event_quota,
	output logic o_generator_run,
	output logic o_trigger_accept,
	output logic o_emit_last_cell_pointer,
	output logic o_emit_empty_channels,
	output logic o_write_clock_tick,
	input wire logic i_converter_frame_line,
	input wire logic i_array_writing_flag,
	input wire logic i_array_reading_flag,
	input wire logic i_readout_busy_flag,
	input wire logic i_write_ready_flag,
	input wire logic i_event_buffer_full,
	input wire logic i_info_queue_full,
	output logic o_array_write_permit,
	input wire logic [`FCLS_NUM_VC-1:0] i_tx_message,
	input wire logic [`FCLS_NUM_VC-1:0] i_rx_message_ok,
	input wire logic [`FCLS_NUM_VC-1:0] i_rx_parity_error,
	input wire logic [`FCLS_NUM_VC-1:0] i_rx_format_error
);
	localparam int TEST_DEPTH = 1 << `FCLS_TEST_AW;

	fcls_pkg::fcls_state_t q, d;
	logic [11:0] test_mem [TEST_DEPTH];
	logic mem_we;
	logic [31:0] msg_word;

	fcls_cnt_if cnt_if();

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] fcls_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return (r & mask) | (old_v & ~mask);
	endfunction

	function automatic logic fcls_thr_hit(input logic [7:0] thr, input logic [7:0] mult);
		return thr != 8'h00 && mult > thr;
	endfunction

	function automatic logic [7:0] fcls_div_last(input logic [7:0] div);
		return (div == 8'h00) ? 8'h00 : div - 8'h01;
	endfunction

	// ----------------------------------------
	// link counter bank
	// ----------------------------------------
	assign cnt_if.capture = q.lnk[`FCLS_LNK_CAPTURE] && !q.cap_prev;
	assign cnt_if.clear = q.lnk[`FCLS_LNK_CLEAR];
	assign cnt_if.chan = q.lnk[`FCLS_LNK_CHAN];
	assign cnt_if.dir = q.lnk[`FCLS_LNK_DIR];
	assign cnt_if.ev_tx = i_tx_message;
	assign cnt_if.ev_rx = i_rx_message_ok;
	assign cnt_if.ev_par = i_rx_parity_error;
	assign cnt_if.ev_fmt = i_rx_format_error;

	fcls_link_counters u_counters (
		.i_clock(i_clock),
		.i_clk_en(i_clk_en),
		.i_rst(i_rst),
		.bank(cnt_if.bank)
	);

	// kind bit ignored for transmit; channel C follows A and B
	always_comb begin
		if (q.lnk[`FCLS_LNK_DIR] || !q.lnk[`FCLS_LNK_KIND]) begin
			msg_word = cnt_if.cap_msg;
		end else begin
			msg_word = {16'h0000, cnt_if.cap_ferr, cnt_if.cap_perr};
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		mem_we = 1'b0;

		// register writes
		case (q.wst)
			fcls_pkg::FCLS_WR_COLLECT: begin
				if (i_awvalid && q.awready) begin
					d.aw_got = 1'b1;
					d.awaddr = i_awaddr;
				end
				if (i_wvalid && q.wready) begin
					d.w_got = 1'b1;
					d.wdata = i_wdata;
					d.wstrb = i_wstrb;
				end
				if (q.aw_got && q.w_got) begin
					d.bresp = `FCLS_RESP_OKAY;
					case (q.awaddr)
						`FCLS_OFF_THRESH: begin
							d.thr = fcls_merge(q.thr, q.wdata, q.wstrb, `FCLS_THR_RW_MASK);
						end
						`FCLS_OFF_CONFIG: begin
							d.cfg = fcls_merge(q.cfg, q.wdata, q.wstrb, `FCLS_CFG_RW_MASK);
						end
						`FCLS_OFF_LINKCTL: begin
							d.lnk = fcls_merge(q.lnk, q.wdata, q.wstrb, `FCLS_LNK_RW_MASK);
						end
						`FCLS_OFF_PATTERN: begin
							mem_we = q.wstrb[0];
							d.load_ptr = q.load_ptr + 4'h1;
						end
						`FCLS_OFF_MSGCNT: begin
							d.bresp = `FCLS_RESP_OKAY;
						end
						default: begin
							d.bresp = `FCLS_RESP_SLVERR;
						end
					endcase
					d.aw_got = 1'b0;
					d.w_got = 1'b0;
					d.wst = fcls_pkg::FCLS_WR_RESP;
				end
			end
			fcls_pkg::FCLS_WR_RESP: begin
				if (i_bready) begin
					d.wst = fcls_pkg::FCLS_WR_COLLECT;
				end
			end
			default: begin
				d.wst = fcls_pkg::FCLS_WR_COLLECT;
			end
		endcase
		d.awready = d.wst == fcls_pkg::FCLS_WR_COLLECT && !d.aw_got;
		d.wready = d.wst == fcls_pkg::FCLS_WR_COLLECT && !d.w_got;

		// register reads
		case (q.rst)
			fcls_pkg::FCLS_RD_IDLE: begin
				if (i_arvalid && q.arready) begin
					d.rst = fcls_pkg::FCLS_RD_DATA;
					d.rresp = `FCLS_RESP_OKAY;
					case (i_araddr)
						`FCLS_OFF_THRESH: d.rdata = q.thr;
						`FCLS_OFF_CONFIG: begin
							d.rdata = q.cfg;
							d.rdata[`FCLS_CFG_STATUS] = q.status;
						end
						`FCLS_OFF_LINKCTL: d.rdata = q.lnk;
						`FCLS_OFF_MSGCNT: d.rdata = msg_word;
						`FCLS_OFF_PATTERN: d.rdata = {28'h0000000, q.load_ptr};
						default: begin
							d.rdata = 32'h00000000;
							d.rresp = `FCLS_RESP_SLVERR;
						end
					endcase
				end
			end
			fcls_pkg::FCLS_RD_DATA: begin
				if (i_rready) begin
					d.rst = fcls_pkg::FCLS_RD_IDLE;
				end
			end
			default: begin
				d.rst = fcls_pkg::FCLS_RD_IDLE;
			end
		endcase
		d.arready = d.rst == fcls_pkg::FCLS_RD_IDLE;

		// capture edge reference
		d.cap_prev = q.lnk[`FCLS_LNK_CAPTURE];

		// local multiplicity triggers
		for (int c = 0; c < `FCLS_NUM_CHIP; c++) begin
			d.local_trig[c] = fcls_thr_hit(q.thr[c*8 +: 8], i_multiplicity[c*8 +: 8]);
		end

		// zero-suppression input source
		if (i_sample_valid) begin
			if (!q.cfg[`FCLS_CFG_TEST_EN]) begin
				d.zs_sample = i_adc_sample;
			end else if (!q.cfg[`FCLS_CFG_TEST_MODE]) begin
				d.zs_sample = i_sample_address;
			end else begin
				d.zs_sample = test_mem[q.rd_ptr];
				d.rd_ptr = q.rd_ptr + 4'h1;
			end
		end

		// event buffer data source
		d.buf_data = q.cfg[`FCLS_CFG_BUF_TEST] ? i_event_buffer_pointer : i_adc_sample;

		// event quota policy, zero quota is unlimited
		if (!i_acq_enable) begin
			d.ev_cnt = 32'h00000000;
		end else if ((q.cfg[`FCLS_CFG_GEN_LIMIT] ? i_gen_event : i_event_captured)
			&& (i_event_quota == 32'h00000000 || q.ev_cnt < i_event_quota)) begin
			d.ev_cnt = q.ev_cnt + 32'h00000001;
		end
		if (i_event_quota != 32'h00000000 && d.ev_cnt >= i_event_quota) begin
			d.gen_run = !q.cfg[`FCLS_CFG_GEN_LIMIT];
			d.trig_accept = q.cfg[`FCLS_CFG_GEN_LIMIT];
		end else begin
			d.gen_run = 1'b1;
			d.trig_accept = 1'b1;
		end

		// write clock divider
		if (q.div_cnt >= fcls_div_last(q.cfg[`FCLS_CFG_DIVISOR])) begin
			d.div_cnt = 8'h00;
			d.tick = 1'b1;
		end else begin
			d.div_cnt = q.div_cnt + 8'h01;
			d.tick = 1'b0;
		end

		// frame line delineation
		d.fs1 = i_converter_frame_line;
		d.fs2 = q.fs1;
		d.window = {q.window[10:0], q.fs2};
		if (q.window == `FCLS_FRAME_PATTERN) begin
			d.locked = q.phase == `FCLS_FRAME_LAST;
			d.phase = 4'h0;
		end else if (q.phase == `FCLS_FRAME_LAST) begin
			d.locked = 1'b0;
			d.phase = 4'h0;
		end else begin
			d.phase = q.phase + 4'h1;
		end

		// acquisition status
		d.status = {i_info_queue_full, i_event_buffer_full, i_write_ready_flag,
			i_readout_busy_flag, i_array_reading_flag, i_array_writing_flag, q.locked};
		d.permit = i_write_ready_flag && !i_event_buffer_full && !i_info_queue_full;
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
			q.wst <= fcls_pkg::FCLS_WR_COLLECT;
			q.rst <= fcls_pkg::FCLS_RD_IDLE;
			q.cfg <= `FCLS_CFG_RESET;
		end else if (i_clk_en) begin
			q <= d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_clk_en && mem_we) begin
			test_mem[q.load_ptr] <= q.wdata[11:0];
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_awready = q.awready;
	assign o_wready = q.wready;
	assign o_bvalid = q.wst[1];
	assign o_bresp = q.bresp;
	assign o_arready = q.arready;
	assign o_rvalid = q.rst[1];
	assign o_rdata = q.rdata;
	assign o_rresp = q.rresp;
	assign o_local_trigger = q.local_trig;
	assign o_zs_sample = q.zs_sample;
	assign o_presamples_count = q.cfg[`FCLS_CFG_PRE];
	assign o_pre_post_sample_total = q.cfg[`FCLS_CFG_TOTAL];
	assign o_buffer_data = q.buf_data;
	assign o_generator_run = q.gen_run;
	assign o_trigger_accept = q.trig_accept;
	assign o_emit_last_cell_pointer = q.cfg[`FCLS_CFG_EMIT_LAST];
	assign o_emit_empty_channels = q.cfg[`FCLS_CFG_EMIT_EMPTY];
	assign o_write_clock_tick = q.tick;
	assign o_array_write_permit = q.permit;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	sequence s_latch_rise;
		i_clk_en && !q.lnk[`FCLS_LNK_CAPTURE] ##1 q.lnk[`FCLS_LNK_CAPTURE];
	endsequence

	sequence s_tick_div2;
		i_clk_en && o_write_clock_tick && q.cfg[`FCLS_CFG_DIVISOR] == 8'h02
		##1 i_clk_en && q.cfg[`FCLS_CFG_DIVISOR] == 8'h02;
	endsequence

	a_thr_zero_ignored: assert property (
		i_clk_en && q.thr[7:0] == 8'h00 |=> !o_local_trigger[0])
		else $error("zero threshold produced a trigger");
	a_thr_compare: assert property (
		i_clk_en && q.thr[23:16] != 8'h00 && i_multiplicity[23:16] > q.thr[23:16]
		|=> o_local_trigger[2])
		else $error("multiplicity above threshold missed");
	a_adc_source: assert property (
		i_clk_en && i_sample_valid && !q.cfg[`FCLS_CFG_TEST_EN]
		|=> o_zs_sample == $past(i_adc_sample))
		else $error("converter sample not passed through");
	a_addr_source: assert property (
		i_clk_en && i_sample_valid && q.cfg[`FCLS_CFG_TEST_EN] && !q.cfg[`FCLS_CFG_TEST_MODE]
		|=> o_zs_sample == $past(i_sample_address))
		else $error("address test data wrong");
	a_buffer_source: assert property (
		i_clk_en && q.cfg[`FCLS_CFG_BUF_TEST] |=> o_buffer_data == $past(i_event_buffer_pointer))
		else $error("buffer test did not write the pointer");
	a_capture_rise: assert property (
		s_latch_rise ##0 i_clk_en |-> cnt_if.capture ##1 !cnt_if.capture)
		else $error("latch rise did not give one capture");
	a_tick_period: assert property (
		s_tick_div2 |=> o_write_clock_tick)
		else $error("divide by two tick missing");
	a_write_permit: assert property (
		i_clk_en && (i_event_buffer_full || i_info_queue_full) |=> !o_array_write_permit)
		else $error("array write permitted while full");
	a_quota_stop: assert property (
		i_clk_en && i_acq_enable && q.cfg[`FCLS_CFG_GEN_LIMIT] && i_event_quota != 32'h0
		&& q.ev_cnt >= i_event_quota |=> !o_generator_run)
		else $error("generator ran past its quota");
	a_frame_lock: assert property (
		i_clk_en && !q.locked ##1 q.locked |-> $past(q.window) == `FCLS_FRAME_PATTERN)
		else $error("lock without framing pattern");
endmodule

// ### dv/fcls_link_partner.sv
`timescale 1ns/1ns

// ----------------------------------------
// concentrator side of the link
// ----------------------------------------
module fcls_link_partner (
	input wire logic i_clock,
	output logic [2:0] o_tx,
	output logic [2:0] o_rx_ok,
	output logic [2:0] o_par,
	output logic [2:0] o_fmt
);
	initial begin
		o_tx = 3'h0;
		o_rx_ok = 3'h0;
		o_par = 3'h0;
		o_fmt = 3'h0;
	end

	// one message per cycle while the line is high
	task automatic send(input int kind, input int vc, input int n);
		logic [2:0] m;
		m = 3'h1 << vc;
		@(posedge i_clock);
		case (kind)
			0: o_tx <= m;
			1: o_rx_ok <= m;
			2: o_par <= m;
			default: o_fmt <= m;
		endcase
		repeat (n) @(posedge i_clock);
		o_tx <= 3'h0;
		o_rx_ok <= 3'h0;
		o_par <= 3'h0;
		o_fmt <= 3'h0;
	endtask
endmodule

// ### dv/tb_frontend_config_and_link_stats.sv
`timescale 1ns/1ns
`include "fcls_defs.svh"
`define CHK(n, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("ERROR %s exp %h got %h", n, e, g); \
	end \
end

module tb_frontend_config_and_link_stats;
	logic i_clock, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic i_sample_valid, i_acq_enable, i_gen_event, i_converter_frame_line, fr_on;
	logic clk_en, i_event_captured;
	logic [7:0] i_awaddr, i_araddr;
	logic [3:0] i_wstrb, o_local_trigger, o_presamples_count, fr_n;
	logic [31:0] i_wdata, i_multiplicity, i_event_quota, o_rdata, rdat;
	logic [11:0] i_adc_sample, i_sample_address, i_event_buffer_pointer, o_zs_sample;
	logic [11:0] o_buffer_data;
	logic [4:0] o_pre_post_sample_total;
	logic [1:0] o_bresp, o_rresp, resp;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_generator_run, o_trigger_accept;
	logic o_emit_last_cell_pointer, o_emit_empty_channels, o_write_clock_tick;
	logic o_array_write_permit;
	logic [5:0] st;
	logic [2:0] i_tx_message, i_rx_message_ok, i_rx_parity_error, i_rx_format_error;
	int err_total, tests_run, n;

	fcls_top dut (.i_clock, .i_clk_en(clk_en), .i_rst, .i_awvalid, .o_awready, .i_awaddr,
		.i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
		.o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_multiplicity,
		.o_local_trigger, .i_sample_valid, .i_adc_sample, .i_sample_address, .o_zs_sample,
		.o_presamples_count, .o_pre_post_sample_total, .i_event_buffer_pointer, .o_buffer_data,
		.i_acq_enable, .i_gen_event, .i_event_captured, .i_event_quota, .o_generator_run,
		.o_trigger_accept, .o_emit_last_cell_pointer, .o_emit_empty_channels,
		.o_write_clock_tick, .i_converter_frame_line, .i_array_writing_flag(st[0]),
		.i_array_reading_flag(st[1]), .i_readout_busy_flag(st[2]), .i_write_ready_flag(st[3]),
		.i_event_buffer_full(st[4]), .i_info_queue_full(st[5]), .o_array_write_permit,
		.i_tx_message, .i_rx_message_ok, .i_rx_parity_error, .i_rx_format_error);

	fcls_link_partner part (.i_clock, .o_tx(i_tx_message), .o_rx_ok(i_rx_message_ok),
		.o_par(i_rx_parity_error), .o_fmt(i_rx_format_error));

	always #2 i_clock = ~i_clock;

	// six ones then six zeros on the framing line
	always @(posedge i_clock) begin
		if (fr_on) begin
			fr_n <= (fr_n == 4'hB) ? 4'h0 : fr_n + 4'h1;
			i_converter_frame_line <= (fr_n < 4'h6);
		end
	end

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		forever begin
			@(posedge i_clock);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (o_bvalid) break;
		end
		resp = o_bresp;
		i_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge i_clock);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		forever begin
			@(posedge i_clock);
			if (o_arready) i_arvalid <= 1'b0;
			if (o_rvalid) break;
		end
		rdat = o_rdata;
		resp = o_rresp;
		i_rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK("register read", e, rdat)
	endtask

	// select, raise the capture bit, then read the captured word
	task automatic lc(input logic [31:0] c, input logic [31:0] e);
		wr(`FCLS_OFF_LINKCTL, c);
		wr(`FCLS_OFF_LINKCTL, c | 32'h00000010);
		repeat (3) @(posedge i_clock);
		rc(`FCLS_OFF_MSGCNT, e);
	endtask

	task automatic samp(input logic [11:0] z, input logic [11:0] b);
		@(posedge i_clock);
		i_sample_valid <= 1'b1;
		@(posedge i_clock);
		i_sample_valid <= 1'b0;
		repeat (2) @(posedge i_clock);
		`CHK("zs sample", z, o_zs_sample)
		`CHK("buffer data", b, o_buffer_data)
	endtask

	task automatic tally_and_finish;
		if (err_total == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		i_clock = 1'b0;
		i_rst = 1'b1;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
		{i_sample_valid, i_acq_enable, i_gen_event, i_converter_frame_line, fr_on} = 5'h00;
		{i_awaddr, i_araddr} = 16'h0000;
		i_wstrb = 4'hF;
		fr_n = 4'h0;
		st = 6'h00;
		clk_en = 1'b1;
		i_event_captured = 1'b0;
		i_wdata = 32'h00000000;
		i_multiplicity = 32'h20200420;
		i_event_quota = 32'h00000002;
		i_adc_sample = 12'h123;
		i_sample_address = 12'hABC;
		i_event_buffer_pointer = 12'h456;
		err_total = 0;
		tests_run = 0;
		repeat (20) @(posedge i_clock);
		i_rst <= 1'b0;
		rc(`FCLS_OFF_CONFIG, `FCLS_CFG_RESET);
		rc(`FCLS_OFF_LINKCTL, 32'h00000000);
		st <= 6'h0A;
		fr_on <= 1'b1;
		repeat (60) @(posedge i_clock);
		rc(`FCLS_OFF_CONFIG, 32'h15010000);
		`CHK("write permit", 1'b1, o_array_write_permit)
		st <= 6'h18;
		repeat (3) @(posedge i_clock);
		`CHK("write permit", 1'b0, o_array_write_permit)
		st <= 6'h00;
		wr(`FCLS_OFF_THRESH, 32'h00100500);
		repeat (3) @(posedge i_clock);
		`CHK("local trigger", 4'h4, o_local_trigger)
		wr(8'h20, 32'hFFFFFFFF);
		`CHK("bresp", `FCLS_RESP_SLVERR, resp)
		rd(8'h20);
		`CHK("rresp", `FCLS_RESP_SLVERR, resp)
		`CHK("rdata", 32'h00000000, rdat)
		wr(`FCLS_OFF_CONFIG, 32'h8002EBFF);
		rc(`FCLS_OFF_CONFIG, 32'h01026BFF);
		`CHK("presamples", 4'hF, o_presamples_count)
		`CHK("pre post total", 5'h1F, o_pre_post_sample_total)
		`CHK("emit flags", 2'h3, {o_emit_last_cell_pointer, o_emit_empty_channels})
		n = 0;
		repeat (30) begin
			@(negedge i_clock);
			n += o_write_clock_tick;
		end
		`CHK("tick count", 15, n)
		samp(12'hABC, 12'h456);
		wr(`FCLS_OFF_PATTERN, 32'h000005A5);
		rc(`FCLS_OFF_PATTERN, 32'h00000001);
		wr(`FCLS_OFF_CONFIG, 32'h00010600);
		samp(12'h5A5, 12'h123);
		wr(`FCLS_OFF_CONFIG, 32'h00011000);
		i_adc_sample <= 12'h7E1;
		samp(12'h7E1, 12'h7E1);
		// clock enable low freezes the sample path
		clk_en <= 1'b0;
		i_adc_sample <= 12'h3C3;
		samp(12'h7E1, 12'h7E1);
		clk_en <= 1'b1;
		i_acq_enable <= 1'b1;
		@(posedge i_clock);
		i_gen_event <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_gen_event <= 1'b0;
		repeat (3) @(posedge i_clock);
		`CHK("generator run", 1'b0, o_generator_run)
		`CHK("trigger accept", 1'b1, o_trigger_accept)
		// captured-event policy: triggers close at the quota
		i_acq_enable <= 1'b0;
		wr(`FCLS_OFF_CONFIG, 32'h00010000);
		i_acq_enable <= 1'b1;
		i_event_captured <= 1'b1;
		@(posedge i_clock);
		i_event_captured <= 1'b0;
		repeat (2) @(posedge i_clock);
		`CHK("trigger accept", 1'b1, o_trigger_accept)
		i_event_captured <= 1'b1;
		@(posedge i_clock);
		i_event_captured <= 1'b0;
		repeat (2) @(posedge i_clock);
		`CHK("trigger accept", 1'b0, o_trigger_accept)
		`CHK("generator run", 1'b1, o_generator_run)
		part.send(0, 0, 5);
		lc(32'h00000004, 32'h00000005);
		part.send(0, 0, 2);
		wr(`FCLS_OFF_LINKCTL, 32'h00000014);
		rc(`FCLS_OFF_MSGCNT, 32'h00000005);
		wr(`FCLS_OFF_LINKCTL, 32'h00000004);
		rc(`FCLS_OFF_MSGCNT, 32'h00000005);
		lc(32'h0000000C, 32'h00000007);
		part.send(1, 1, 3);
		part.send(2, 1, 2);
		part.send(3, 1, 4);
		lc(32'h00000001, 32'h00000003);
		wr(`FCLS_OFF_LINKCTL, 32'h00000019);
		rc(`FCLS_OFF_MSGCNT, 32'h00000402);
		part.send(2, 2, 260);
		lc(32'h0000000A, 32'h000000FF);
		wr(`FCLS_OFF_LINKCTL, 32'h00000021);
		part.send(1, 1, 3);
		lc(32'h00000001, 32'h00000000);
		lc(32'h00000004, 32'h00000007);
		wr(`FCLS_OFF_LINKCTL, 32'h00000023);
		lc(32'h00000004, 32'h00000000);
		tally_and_finish;
	end

	initial begin
		repeat (20000) @(posedge i_clock);
		err_total++;
		tally_and_finish;
	end
endmodule
